// >>> src/debug_port_auth_ident.v
`timescale 1ns/1ps
`include "dbg_consts.vh"

module debug_port_auth_ident #(
  parameter [7:0] IDENT_0_VALUE = 8'hA1, // arbitrary value
  parameter [7:0] IDENT_1_VALUE = 8'hA2, // arbitrary value
  parameter [7:0] IDENT_2_VALUE = 8'hA3, // arbitrary value
  parameter [7:0] IDENT_3_VALUE = 8'hA4  // arbitrary value
) (
  input wire clk_in,
  input wire nrst_in,
  input wire ce_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [12:2] debug_apb_address_in,
  input wire access_source_indicator_in,
  input wire [31:0] pwdata_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  input wire secure_invasive_enable_in,
  input wire invasive_debug_enable_in,
  input wire secure_noninvasive_enable_in,
  input wire noninvasive_debug_enable_in,
  input wire secure_user_invasive_ctrl_in,
  input wire [1:0] mode_select_in,
  input wire secure_in,
  input wire user_mode_in,
  input wire halt_req_in,
  input wire bkpt_in,
  input wire watchpoint_hit_in,
  input wire sync_abort_in,
  input wire cache_maint_in,
  input wire async_abort_pending_in,
  input wire restart_in,
  output reg s_inv_perm_out,
  output reg ns_inv_perm_out,
  output reg s_ninv_perm_out,
  output reg ns_ninv_perm_out,
  output reg event_ignored_out,
  output reg debug_exception_out,
  output reg abort_taken_out,
  output reg debug_state_out,
  output reg [3:0] entry_method_out
);

  // ************************************
  // state encoding
  // ************************************
  localparam [2:0] ST_RUN = 3'b001;
  localparam [2:0] ST_DRAIN = 3'b010;
  localparam [2:0] ST_HALTED = 3'b100;

  // ************************************
  // declarations
  // ************************************
  reg [2:0] state;
  reg [2:0] next_state;
  reg [31:0] next_prdata;
  reg next_pslverr;
  reg last_src_external;
  reg abort_seen;
  reg [3:0] pending_method;
  wire [7:0] ident_rom [0:3];
  wire s_inv;
  wire ns_inv;
  wire s_ninv;
  wire ns_ninv;
  wire inv_sync;
  wire sinv_sync;
  wire act_ignore;
  wire act_exception;
  wire act_enter;
  wire abort_take;
  wire [3:0] method;
  wire access_phase;
  wire in_monitor_area;
  wire [11:0] area_offset;
  wire [1:0] ident_idx;
  wire ev_live;

  // ************************************
  // decode helpers
  // ************************************

  // true when an area offset falls on one of the ident words
  function is_ident;
    input [11:0] ofs;
    begin
      is_ident = ((ofs & `IDENT_MASK) == `OFS_IDENT_0);
    end
  endfunction

  // pack the four permissions in status order
  function [3:0] pack_auth;
    input ns_i;
    input ns_n;
    input s_i;
    input s_n;
    reg [3:0] w;
    begin
      w = 4'h0;
      w[`AUTH_NS_INV_BIT] = ns_i;
      w[`AUTH_NS_NINV_BIT] = ns_n;
      w[`AUTH_S_INV_BIT] = s_i;
      w[`AUTH_S_NINV_BIT] = s_n;
      pack_auth = w;
    end
  endfunction

  // ************************************
  // fixed identification words
  // ************************************
  assign ident_rom[0] = IDENT_0_VALUE;
  assign ident_rom[1] = IDENT_1_VALUE;
  assign ident_rom[2] = IDENT_2_VALUE;
  assign ident_rom[3] = IDENT_3_VALUE;

  // ************************************
  // authentication pins and permissions
  // ************************************
  auth_sync #(
    .N_AUTH(4)
  ) u_auth_sync (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .secure_invasive_enable_in(secure_invasive_enable_in),
    .invasive_debug_enable_in(invasive_debug_enable_in),
    .secure_noninvasive_enable_in(secure_noninvasive_enable_in),
    .noninvasive_debug_enable_in(noninvasive_debug_enable_in),
    .s_inv_out(s_inv),
    .ns_inv_out(ns_inv),
    .s_ninv_out(s_ninv),
    .ns_ninv_out(ns_ninv),
    .invasive_sync_out(inv_sync),
    .secure_inv_sync_out(sinv_sync)
  );

  // ************************************
  // debug event resolution
  // ************************************
  event_arbiter u_event_arbiter (
    .halt_req_in(halt_req_in),
    .bkpt_in(bkpt_in),
    .watchpoint_hit_in(watchpoint_hit_in),
    .sync_abort_in(sync_abort_in),
    .cache_maint_in(cache_maint_in),
    .secure_in(secure_in),
    .user_mode_in(user_mode_in),
    .s_inv_in(s_inv & sinv_sync),
    .ns_inv_in(ns_inv),
    .invasive_in(inv_sync),
    .secure_user_invasive_ctrl_in(secure_user_invasive_ctrl_in),
    .mode_select_in(mode_select_in),
    .act_ignore_out(act_ignore),
    .act_exception_out(act_exception),
    .act_enter_out(act_enter),
    .abort_take_out(abort_take),
    .method_out(method)
  );

  // events count only while the core runs normally
  assign ev_live = (state == ST_RUN);

  // ************************************
  // debug entry state machine
  // ************************************
  always @* begin
    case (state)
      ST_RUN: begin
        if (act_enter)
          next_state = ST_DRAIN;
        else
          next_state = ST_RUN;
      end
      ST_DRAIN: begin
        // wait until no asynchronous abort is still in flight
        if (!async_abort_pending_in)
          next_state = ST_HALTED;
        else
          next_state = ST_DRAIN;
      end
      ST_HALTED: begin
        if (restart_in)
          next_state = ST_RUN;
        else
          next_state = ST_HALTED;
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  // state register, outcome pulses and entry method
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      state <= ST_RUN;
      pending_method <= `METHOD_RESET;
      entry_method_out <= `METHOD_RESET;
      debug_state_out <= 1'b0;
      event_ignored_out <= 1'b0;
      debug_exception_out <= 1'b0;
      abort_taken_out <= 1'b0;
      abort_seen <= 1'b0;
    end else if (ce_in) begin
      state <= next_state;
      event_ignored_out <= ev_live & act_ignore;
      debug_exception_out <= ev_live & act_exception;
      abort_taken_out <= ev_live & abort_take;
      if (ev_live & abort_take)
        abort_seen <= 1'b1;
      else if (restart_in & (state == ST_HALTED))
        abort_seen <= 1'b0;
      if (ev_live & act_enter)
        pending_method <= method;
      // debug state is shown only once the drain has finished
      if ((state == ST_DRAIN) & !async_abort_pending_in) begin
        debug_state_out <= 1'b1;
        entry_method_out <= pending_method;
      end else if ((state == ST_HALTED) & restart_in) begin
        debug_state_out <= 1'b0;
      end
    end
  end

  // ************************************
  // permission outputs
  // ************************************
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      s_inv_perm_out <= 1'b0;
      ns_inv_perm_out <= 1'b0;
      s_ninv_perm_out <= 1'b0;
      ns_ninv_perm_out <= 1'b0;
    end else if (ce_in) begin
      s_inv_perm_out <= s_inv;
      ns_inv_perm_out <= ns_inv;
      s_ninv_perm_out <= s_ninv;
      ns_ninv_perm_out <= ns_ninv;
    end
  end

  // ************************************
  // apb slave
  // ************************************
  assign access_phase = psel_in & penable_in & ~pready_out;
  assign in_monitor_area = debug_apb_address_in[`AREA_SEL_BIT];
  assign area_offset = {debug_apb_address_in[11:2], 2'b00};
  assign ident_idx = debug_apb_address_in[3:2];

  // read data and error for the current access
  always @*begin
    next_prdata = `WORD_ZERO;
    next_pslverr = 1'b0;
    if (in_monitor_area) begin
      // monitor area lives elsewhere, so answer with an error
      next_pslverr = 1'b1;
    end else if (!pwrite_in) begin
      if (is_ident(area_offset))
        next_prdata[`IDENT_WIDTH-1:0] = ident_rom[ident_idx];
      else if (area_offset == `OFS_AUTH_STATUS)
        next_prdata[3:0] = pack_auth(ns_inv, ns_ninv, s_inv, s_ninv);
      else if (area_offset == `OFS_EVENT_STATUS) begin
        next_prdata[`EVT_DEBUG_BIT] = debug_state_out;
        next_prdata[`EVT_DRAIN_BIT] = (state == ST_DRAIN);
        next_prdata[`EVT_METHOD_MSB:`EVT_METHOD_LSB] = entry_method_out;
        next_prdata[`EVT_SRC_BIT] = last_src_external;
        next_prdata[`EVT_ABORT_BIT] = abort_seen;
      end
    end
    // writes to ident words are dropped, nothing here stores them
  end

  // one wait state per access, answer registered
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= `WORD_ZERO;
      last_src_external <= 1'b0;
    end else if (ce_in) begin
      pready_out <= access_phase;
      if (access_phase) begin
        pslverr_out <= next_pslverr;
        prdata_out <= next_prdata;
        last_src_external <= access_source_indicator_in;
      end else begin
        pslverr_out <= 1'b0;
        prdata_out <= `WORD_ZERO;
      end
    end
  end

  // pwdata_in has no storage target: all mapped words are read-only
  // an async abort meeting a watchpoint is not linked to it here

endmodule // debug_port_auth_ident

// >>> src/dbg_consts.vh
`ifndef DBG_CONSTS_VH
`define DBG_CONSTS_VH

// ************************************
// apb address map, byte offsets in an area
// ************************************
`define AREA_SEL_BIT 12
`define OFS_IDENT_0 12'hFF0
`define OFS_IDENT_1 12'hFF4
`define OFS_IDENT_2 12'hFF8
`define OFS_IDENT_3 12'hFFC
`define IDENT_MASK 12'hFF0
`define OFS_AUTH_STATUS 12'hFB8
`define OFS_EVENT_STATUS 12'h0F0

// ************************************
// field layout
// ************************************
`define IDENT_WIDTH 8
`define AUTH_NS_INV_BIT 0
`define AUTH_NS_NINV_BIT 1
`define AUTH_S_INV_BIT 2
`define AUTH_S_NINV_BIT 3
`define EVT_DEBUG_BIT 0
`define EVT_DRAIN_BIT 1
`define EVT_METHOD_LSB 2
`define EVT_METHOD_MSB 5
`define EVT_SRC_BIT 6
`define EVT_ABORT_BIT 7

// ************************************
// reset values and encodings
// ************************************
`define WORD_ZERO 32'h0000_0000
`define METHOD_RESET 4'h0
`define METHOD_BKPT 4'h1
`define METHOD_EXT_HALT 4'h4
`define METHOD_SYNC_WP 4'hA
`define MODE_NONE 2'b00
`define MODE_HALT 2'b01
`define MODE_MONITOR 2'b10
`define SYNC_DEPTH 2

`endif

// >>> src/auth_sync.v
`timescale 1ns/1ps
`include "dbg_consts.vh"

module auth_sync #(
  parameter N_AUTH = 4
) (
  input wire clk_in,
  input wire nrst_in,
  input wire ce_in,
  input wire secure_invasive_enable_in,
  input wire invasive_debug_enable_in,
  input wire secure_noninvasive_enable_in,
  input wire noninvasive_debug_enable_in,
  output reg s_inv_out,
  output reg ns_inv_out,
  output reg s_ninv_out,
  output reg ns_ninv_out,
  output reg invasive_sync_out,
  output reg secure_inv_sync_out
);

  wire [N_AUTH-1:0] raw;
  wire [N_AUTH-1:0] synced;

  assign raw = {secure_invasive_enable_in, invasive_debug_enable_in,
                secure_noninvasive_enable_in, noninvasive_debug_enable_in};

  // ************************************
  // two flop synchronisers, one per pin
  // ************************************
  genvar g;
  generate
    for (g = 0; g < N_AUTH; g = g + 1) begin : g_sync
      reg meta;
      reg stable;
      always @(posedge clk_in) begin
        if (!nrst_in) begin
          meta <= 1'b0;
          stable <= 1'b0;
        end else if (ce_in) begin
          meta <= raw[g];
          stable <= meta;
        end
      end
      assign synced[g] = stable;
    end
  endgenerate

  // ************************************
  // permission decode from clean levels
  // ************************************
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      s_inv_out <= 1'b0;
      ns_inv_out <= 1'b0;
      s_ninv_out <= 1'b0;
      ns_ninv_out <= 1'b0;
      invasive_sync_out <= 1'b0;
      secure_inv_sync_out <= 1'b0;
    end else if (ce_in) begin
      s_inv_out <= synced[3] & synced[2];
      ns_inv_out <= synced[2];
      s_ninv_out <= (synced[3] | synced[1]) & (synced[2] | synced[0]);
      ns_ninv_out <= synced[2] | synced[0];
      invasive_sync_out <= synced[2];
      secure_inv_sync_out <= synced[3];
    end
  end

endmodule // auth_sync

// >>> src/event_arbiter.v
`timescale 1ns/1ps
`include "dbg_consts.vh"

module event_arbiter (
  input wire halt_req_in,
  input wire bkpt_in,
  input wire watchpoint_hit_in,
  input wire sync_abort_in,
  input wire cache_maint_in,
  input wire secure_in,
  input wire user_mode_in,
  input wire s_inv_in,
  input wire ns_inv_in,
  input wire invasive_in,
  input wire secure_user_invasive_ctrl_in,
  input wire [1:0] mode_select_in,
  output reg act_ignore_out,
  output reg act_exception_out,
  output reg act_enter_out,
  output reg abort_take_out,
  output reg [3:0] method_out
);

  reg wp_live;
  reg sw_event;
  reg [1:0] eff_mode;
  reg halt_ok;
  reg mon_ok;

  // ************************************
  // one outcome per event
  // ************************************
  always @* begin
    abort_take_out = sync_abort_in;
    // abort wins over a watchpoint; maintenance never watches
    wp_live = watchpoint_hit_in & ~cache_maint_in & ~sync_abort_in;
    sw_event = bkpt_in | wp_live;
    eff_mode = invasive_in ? mode_select_in : `MODE_NONE;
    if (secure_in & user_mode_in) begin
      halt_ok = s_inv_in;
      mon_ok = s_inv_in | (invasive_in & secure_user_invasive_ctrl_in);
    end else if (secure_in) begin
      halt_ok = s_inv_in;
      mon_ok = s_inv_in;
    end else begin
      halt_ok = ns_inv_in;
      mon_ok = ns_inv_in;
    end
    act_ignore_out = 1'b0;
    act_exception_out = 1'b0;
    act_enter_out = 1'b0;
    method_out = `METHOD_RESET;
    if (halt_req_in) begin
      method_out = `METHOD_EXT_HALT;
      // halting events ignored without invasive enable
      if (invasive_in & halt_ok)
        act_enter_out = 1'b1;
      else
        act_ignore_out = 1'b1;
    end else if (sw_event) begin
      // watchpoints always report the synchronous code
      method_out = wp_live ? `METHOD_SYNC_WP : `METHOD_BKPT;
      if ((eff_mode == `MODE_HALT) & halt_ok)
        act_enter_out = 1'b1;
      else if ((eff_mode == `MODE_MONITOR) & mon_ok)
        act_exception_out = 1'b1;
      else
        act_ignore_out = 1'b1;
    end
  end

endmodule // event_arbiter

// >>> tb/debug_port_auth_ident_assertions.sv
`timescale 1ns/1ps
module debug_port_auth_ident_assertions (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [12:2] debug_apb_address_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic halt_req_in,
  input wire logic bkpt_in,
  input wire logic watchpoint_hit_in,
  input wire logic sync_abort_in,
  input wire logic cache_maint_in,
  input wire logic async_abort_pending_in,
  input wire logic s_inv_perm_out,
  input wire logic ns_inv_perm_out,
  input wire logic s_ninv_perm_out,
  input wire logic ns_ninv_perm_out,
  input wire logic event_ignored_out,
  input wire logic debug_exception_out,
  input wire logic debug_state_out,
  input wire logic [3:0] entry_method_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // ************************************
  // apb access steps
  // ************************************
  sequence taken_s; psel_in && penable_in && !pready_out; endsequence
  sequence answer_s; pready_out ##1 !pready_out; endsequence
  sequence wp_killed_s; !debug_exception_out ##1 !$rose(debug_state_out); endsequence
  wait_state_a: assert property (taken_s |=> answer_s)
    else $error("apb answer not one cycle after access");
  area_err_a: assert property (pready_out |-> pslverr_out == $past(debug_apb_address_in[12]))
    else $error("error response does not follow area bit");
  ident_upper_a: assert property (
    pready_out && $past(debug_apb_address_in[11:4]) == 8'hFF |-> prdata_out[31:8] == 24'h0)
    else $error("ident upper bits not zero");
  // ************************************
  // events and permissions
  // ************************************
  method_code_a: assert property (entry_method_out != 4'h2)
    else $error("forbidden entry method");
  perm_order_a: assert property (s_inv_perm_out |-> ns_inv_perm_out && s_ninv_perm_out)
    else $error("secure invasive without its prerequisites");
  ns_noninv_a: assert property (ns_inv_perm_out |-> ns_ninv_perm_out)
    else $error("non-secure non-invasive missing");
  cache_wp_a: assert property (
    watchpoint_hit_in && cache_maint_in && !halt_req_in && !bkpt_in |=> wp_killed_s)
    else $error("cache maintenance raised a watchpoint");
  abort_wins_a: assert property (
    watchpoint_hit_in && sync_abort_in && !halt_req_in && !bkpt_in |=> wp_killed_s)
    else $error("watchpoint beat synchronous abort");
  one_action_a: assert property (
    $onehot0({event_ignored_out, debug_exception_out, $rose(debug_state_out)}))
    else $error("more than one event action");
  drain_first_a: assert property ($rose(debug_state_out) |-> !$past(async_abort_pending_in))
    else $error("debug entry with abort pending");
  halt_off_a: assert property (
    halt_req_in && !ns_inv_perm_out && !debug_state_out |=> wp_killed_s)
    else $error("halting event acted on while disabled");
endmodule // debug_port_auth_ident_assertions

bind debug_port_auth_ident debug_port_auth_ident_assertions chk_i (.clk_in(clk_in),
  .nrst_in(nrst_in), .psel_in(psel_in), .penable_in(penable_in),
  .debug_apb_address_in(debug_apb_address_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .halt_req_in(halt_req_in),
  .bkpt_in(bkpt_in), .watchpoint_hit_in(watchpoint_hit_in), .sync_abort_in(sync_abort_in),
  .cache_maint_in(cache_maint_in), .async_abort_pending_in(async_abort_pending_in),
  .s_inv_perm_out(s_inv_perm_out), .ns_inv_perm_out(ns_inv_perm_out),
  .s_ninv_perm_out(s_ninv_perm_out), .ns_ninv_perm_out(ns_ninv_perm_out),
  .event_ignored_out(event_ignored_out), .debug_exception_out(debug_exception_out),
  .debug_state_out(debug_state_out), .entry_method_out(entry_method_out));

// >>> tb/apb_debug_master.sv
`timescale 1ns/1ps
module apb_debug_master (
  input wire logic clk_in,
  input wire logic pready_in,
  input wire logic pslverr_in,
  input wire logic [31:0] prdata_in,
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [12:2] addr_out,
  output logic src_out,
  output logic [31:0] wdata_out
);
  // idle bus at time zero
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    addr_out = 11'h0;
    src_out = 1'b0;
    wdata_out = 32'h0;
  end
  // one access: setup, enable, hold until ready, then release with scrambled lines
  task automatic xfer(input logic wr, input logic [12:2] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge clk_in);
    psel_out <= 1'b1;
    pwrite_out <= wr;
    addr_out <= a;
    src_out <= 1'b1;
    wdata_out <= wd;
    @(posedge clk_in);
    penable_out <= 1'b1;
    // hold the request until ready is seen high at a rising edge, take the answer there
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_in !== 1'b1 && n < 16);
    rd = prdata_in;
    er = (pready_in === 1'b1) ? pslverr_in : 1'bx;
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    pwrite_out <= ~wr;
    addr_out <= ~a;
    src_out <= 1'b0;
    wdata_out <= ~wd;
  endtask
endmodule // apb_debug_master

// >>> tb/debug_port_auth_ident_bench.sv
`timescale 1ns/1ps
module debug_port_auth_ident_bench;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic psel, penable, pwrite, src, pready, pslverr, er;
  logic [12:2] addr;
  logic [31:0] wdata, prdata, rd;
  logic [3:0] pin = 4'h0; // secure inv, inv, secure noninv, noninv
  logic ctrl = 1'b0, sec = 1'b0, usr = 1'b0, pend = 1'b0, rst_dbg = 1'b0;
  logic [1:0] mode = 2'b01;
  logic [4:0] stb = 5'h0; // halt, bkpt, watchpoint, sync abort, cache maint
  logic [3:0] perm, meth, pe;
  logic ign, exc, abt, dstate;
  int err_total = 0, n_tests = 0, cycles = 0;
  logic [7:0] idv [4] = '{8'h3C, 8'h5A, 8'h6B, 8'h7E}; // arbitrary values

  always #20 clk_in = ~clk_in;

  apb_debug_master m (.clk_in(clk_in), .pready_in(pready), .pslverr_in(pslverr),
    .prdata_in(prdata), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
    .addr_out(addr), .src_out(src), .wdata_out(wdata));

  debug_port_auth_ident #(.IDENT_0_VALUE(8'h3C), .IDENT_1_VALUE(8'h5A),
    .IDENT_2_VALUE(8'h6B), .IDENT_3_VALUE(8'h7E)) dut (
    .clk_in(clk_in), .nrst_in(nrst_in), .ce_in(1'b1), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .debug_apb_address_in(addr),
    .access_source_indicator_in(src), .pwdata_in(wdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .secure_invasive_enable_in(pin[3]),
    .invasive_debug_enable_in(pin[2]), .secure_noninvasive_enable_in(pin[1]),
    .noninvasive_debug_enable_in(pin[0]), .secure_user_invasive_ctrl_in(ctrl),
    .mode_select_in(mode), .secure_in(sec), .user_mode_in(usr), .halt_req_in(stb[4]),
    .bkpt_in(stb[3]), .watchpoint_hit_in(stb[2]), .sync_abort_in(stb[1]),
    .cache_maint_in(stb[0]), .async_abort_pending_in(pend), .restart_in(rst_dbg),
    .s_inv_perm_out(perm[3]), .ns_inv_perm_out(perm[2]), .s_ninv_perm_out(perm[1]),
    .ns_ninv_perm_out(perm[0]), .event_ignored_out(ign), .debug_exception_out(exc),
    .abort_taken_out(abt), .debug_state_out(dstate), .entry_method_out(meth));

  // ************************************
  // helpers
  // ************************************
  function automatic logic [3:0] perm_of(input logic [3:0] p);
    return {p[3] & p[2], p[2], (p[3] | p[1]) & (p[2] | p[0]), p[2] | p[0]};
  endfunction
  task automatic end_of_test;
    if (err_total == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [12:0] a, input logic [31:0] exp, input logic ee);
    m.xfer(1'b0, a[12:2], 32'h0, rd, er);
    chk(rd, exp);
    chk({31'h0, er}, {31'h0, ee});
  endtask
  // pulse strobes for one cycle, then look at the one-cycle answers
  task automatic ev(input logic [4:0] s, input logic [2:0] e, input logic [2:0] msk);
    @(posedge clk_in);
    stb <= s;
    @(posedge clk_in);
    stb <= 5'h0;
    @(negedge clk_in);
    chk({29'h0, {ign, exc, abt} & msk}, {29'h0, e});
  endtask
  task automatic st(input logic d, input logic [3:0] mm);
    @(negedge clk_in);
    chk({27'h0, dstate, meth}, {27'h0, d, mm});
  endtask
  task automatic restart;
    @(posedge clk_in);
    rst_dbg <= 1'b1;
    @(posedge clk_in);
    rst_dbg <= 1'b0;
    @(negedge clk_in);
    chk({31'h0, dstate}, 32'h0);
  endtask
  task automatic setp(input logic [3:0] p, input logic [1:0] md, input logic s, input logic u);
    @(posedge clk_in);
    pin <= p;
    mode <= md;
    sec <= s;
    usr <= u;
    ctrl <= 1'b1;
    repeat (6) @(posedge clk_in);
  endtask

  // hang guard
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      err_total++;
      end_of_test;
    end
  end

  // ************************************
  // main sequence
  // ************************************
  initial begin
    repeat (4) @(posedge clk_in);
    nrst_in <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd_chk(13'hFF0 + 13'(4 * i), {24'h0, idv[i]}, 1'b0);
      m.xfer(1'b1, 11'h3FC + 11'(i), 32'hFFFF_FFFF, rd, er);
      rd_chk(13'hFF0 + 13'(4 * i), {24'h0, idv[i]}, 1'b0);
    end
    rd_chk(13'h1FF0, 32'h0, 1'b1);
    rd_chk(13'h0004, 32'h0, 1'b0);
    for (int k = 1; k <= 16; k++) begin
      @(posedge clk_in);
      pin <= 4'(k);
      @(negedge clk_in);
      chk({28'h0, perm}, {28'h0, perm_of(4'(k - 1))});
      repeat (4) @(negedge clk_in);
      chk({28'h0, perm}, {28'h0, perm_of(4'(k))});
      pe = perm_of(4'(k));
      rd_chk(13'hFB8, {28'h0, pe[1], pe[3], pe[0], pe[2]}, 1'b0);
    end
    setp(4'hF, 2'b01, 1'b0, 1'b0);
    ev(5'b00101, 3'b000, 3'b111);
    st(1'b0, 4'h0);
    ev(5'b00110, 3'b001, 3'b111);
    st(1'b0, 4'h0);
    rd_chk(13'h00F0, 32'h0000_00C0, 1'b0);
    ev(5'b00100, 3'b000, 3'b111);
    st(1'b1, 4'hA);
    restart;
    @(posedge clk_in);
    pend <= 1'b1;
    ev(5'b10000, 3'b000, 3'b111);
    repeat (3) st(1'b0, 4'hA);
    rd_chk(13'h00F0, 32'h0000_006A, 1'b0);
    @(posedge clk_in);
    pend <= 1'b0;
    @(negedge clk_in);
    st(1'b1, 4'h4);
    restart;
    setp(4'hF, 2'b10, 1'b0, 1'b0);
    ev(5'b01000, 3'b010, 3'b111);
    setp(4'h7, 2'b10, 1'b1, 1'b1);
    ev(5'b01000, 3'b010, 3'b111);
    @(posedge clk_in);
    ctrl <= 1'b0;
    ev(5'b01000, 3'b100, 3'b111);
    setp(4'h7, 2'b01, 1'b1, 1'b1);
    ev(5'b10000, 3'b100, 3'b111);
    st(1'b0, 4'h4);
    setp(4'hF, 2'b01, 1'b1, 1'b1);
    ev(5'b10000, 3'b000, 3'b111);
    st(1'b1, 4'h4);
    restart;
    setp(4'h3, 2'b01, 1'b0, 1'b0);
    ev(5'b10000, 3'b100, 3'b111);
    setp(4'h3, 2'b10, 1'b0, 1'b0);
    ev(5'b01000, 3'b100, 3'b111);
    end_of_test;
  end
endmodule // debug_port_auth_ident_bench
